// [logic/rx_sync_word_qualifier.sv]
/*
  Receive sync word qualifier: sync detection gated by match mode,
  preamble quality and carrier sense; strength latch; carrier sense.
  Assumes demodulator bits and strength samples on mclk, APB master.
*/
// Added by the designer: the register offsets and the APB register port.
`timescale 1ns/10ps
module rx_sync_word_qualifier
  import rxq_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Receiver front end
  input wire logic rx_enable,
  input wire rx_bit_t rx_in,
  input wire logic strength_valid,
  input wire logic [7:0] strength_sample,
  input wire logic byte_valid,
  input wire logic [7:0] byte_data,
  input wire logic payload_done,
  // Outputs
  output logic sync_found,
  output logic data_write,
  output logic [7:0] data_byte,
  output logic filter_enable,
  output logic general_pin,
  output logic tx_invert,
  output logic [2:0] phase_shaping
);

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [7:0] modem_config_two_q;
  logic [7:0] packet_control_one_q;
  logic [7:0] gain_control_one_q;
  logic [7:0] gain_control_two_q;
  logic [15:0] sync_word_q;
  logic [7:0] frequency_deviation_q;
  logic [3:0] output_select_code_q;
  logic [7:0] strength_q;
  logic [7:0] status_byte_q;
  logic [7:0] data_q;
  logic carrier_q;
  logic [7:0] pq_count_q;
  logic [31:0] shift_q;
  logic prev_bit_q;
  logic have_prev_q;
  logic rx_en_q;
  logic [7:0] prev_strength_q;
  logic [10:0] upd_count_q;
  rx_state_t state_q;

  logic [2:0] sync_mode;
  logic cs_qual;
  logic msk_en;
  logic [2:0] preamble_quality_threshold;
  logic [3:0] abs_offset;
  logic [3:0] target_magnitude;
  logic [1:0] rel_thr;
  logic [1:0] filt_len;
  logic pq_reached;
  logic bit_in;
  logic entry;
  logic sync_match;
  logic sync_allowed;
  logic apb_wr;
  logic apb_rd;
  logic [10:0] upd_period;
  logic upd_tick;

  assign sync_mode = modem_config_two_q[sync_mode_lsb +: 3] & 3'h3;
  assign cs_qual = modem_config_two_q[cs_qual_bit];
  assign msk_en = modem_config_two_q[msk_bit];
  assign preamble_quality_threshold = modem_config_two_q[pqt_lsb +: 3];
  assign abs_offset = gain_control_one_q[3:0];
  assign rel_thr = gain_control_one_q[rel_thr_lsb +: 2];
  assign filt_len = gain_control_one_q[filt_len_lsb +: 2];
  assign target_magnitude = gain_control_two_q[3:0];
  assign entry = rx_enable && !rx_en_q;
  assign apb_wr = psel && penable && pwrite;
  assign apb_rd = psel && !penable && !pwrite;

  // inverted sense under minimum shift keying
  assign bit_in = rx_in.bit_val ^ msk_en;

  // ----------------------------------------------------------------
  // APB register writes
  // ----------------------------------------------------------------
  always_ff @(posedge mclk)
  begin
    if (!rst_b)
    begin
      modem_config_two_q <= modem_config_two_rst;
      packet_control_one_q <= packet_control_one_rst;
      gain_control_one_q <= gain_control_one_rst;
      gain_control_two_q <= {4'h0, target_magnitude_rst};
      sync_word_q <= sync_word_rst;
      frequency_deviation_q <= frequency_deviation_rst;
      output_select_code_q <= pin_output_rst;
    end
    else if (apb_wr)
    begin
      case (paddr)
        modem_config_two_off: modem_config_two_q <= pwdata[7:0];
        packet_control_one_off: packet_control_one_q <= pwdata[7:0];
        gain_control_one_off: gain_control_one_q <= pwdata[7:0];
        gain_control_two_off: gain_control_two_q <= pwdata[7:0];
        sync_word_off: sync_word_q <= pwdata[15:0];
        frequency_deviation_reg_off: frequency_deviation_q <= pwdata[7:0];
        pin_output_config_off: output_select_code_q <= pwdata[3:0];
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // APB read and answer
  // ----------------------------------------------------------------
  // Zero-wait answer: ready rises in every access phase
  always_ff @(posedge mclk)
  begin
    if (!rst_b)
    begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready <= psel && !penable;
      pslverr <= 1'b0;
      if (apb_rd)
      begin
        case (paddr)
          modem_config_two_off: prdata <= {24'h0, modem_config_two_q};
          packet_control_one_off: prdata <= {24'h0, packet_control_one_q};
          gain_control_one_off: prdata <= {24'h0, gain_control_one_q};
          gain_control_two_off: prdata <= {24'h0, gain_control_two_q};
          sync_word_off: prdata <= {16'h0, sync_word_q};
          frequency_deviation_reg_off: prdata <= {24'h0, frequency_deviation_q};
          pin_output_config_off: prdata <= {28'h0, output_select_code_q};
          signal_strength_off: prdata <= {24'h0, strength_q};
          packet_status_reg_off: prdata <= {24'h0, carrier_q, pq_reached,
            sync_found, 3'h0, state_q};
          status_byte_off: prdata <= {24'h0, status_byte_q};
          radio_data_register_off: prdata <= {24'h0, data_q};
          default:
          begin
            prdata <= 32'h0000_0000;
            pslverr <= 1'b1;
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Preamble quality
  // ----------------------------------------------------------------
  always_ff @(posedge mclk)
  begin
    if (!rst_b)
    begin
      rx_en_q <= 1'b0;
      prev_bit_q <= 1'b0;
      have_prev_q <= 1'b0;
      pq_count_q <= 8'h00;
      shift_q <= 32'h0000_0000;
    end
    else
    begin
      rx_en_q <= rx_enable;
      if (entry)
      begin
        pq_count_q <= 8'h00;
        have_prev_q <= 1'b0;
        // Stale bits from the last visit must not match
        shift_q <= 32'h0000_0000;
      end
      else if (rx_enable && rx_in.valid)
      begin
        prev_bit_q <= bit_in;
        have_prev_q <= 1'b1;
        shift_q <= {shift_q[30:0], bit_in};
        if (have_prev_q)
        begin
          if (bit_in != prev_bit_q)
            pq_count_q <= (pq_count_q == pq_max) ? pq_max : pq_count_q + 8'h01;
          else
            pq_count_q <= (pq_count_q < pq_repeat_step) ? 8'h00 : pq_count_q - pq_repeat_step;
        end
      end
    end
  end

  assign pq_reached = (preamble_quality_threshold == 3'h0) || (pq_count_q > {3'h0, preamble_quality_threshold, 2'b00});

  // ----------------------------------------------------------------
  // Sync match
  // ----------------------------------------------------------------
  function automatic logic [5:0] ones16(input logic [15:0] v);
    logic [5:0] n;
    n = 6'h00;
    for (int i = 0; i < 16; i++)
      n = n + {5'h00, v[i]};
    return n;
  endfunction

  always_comb
  begin
    logic [5:0] hi;
    logic [5:0] lo;
    logic [31:0] nxt;
    // Judge the word including the bit arriving now
    nxt = {shift_q[30:0], bit_in};
    hi = ones16(~(nxt[31:16] ^ sync_word_q));
    lo = ones16(~(nxt[15:0] ^ sync_word_q));
    // 32-bit mode uses the word twice
    case (sync_mode)
      mode_15of16: sync_match = lo >= 6'd15;
      mode_16of16: sync_match = lo == 6'd16;
      mode_30of32: sync_match = (hi + lo) >= 6'd30;
      default: sync_match = 1'b0;
    endcase
  end

  // upper modes also need carrier sense
  assign sync_allowed = pq_reached && (!cs_qual || carrier_q);

  // ----------------------------------------------------------------
  // Receive state
  // ----------------------------------------------------------------
  always_ff @(posedge mclk)
  begin
    if (!rst_b)
      state_q <= st_idle;
    else if (!rx_enable)
      state_q <= st_idle;
    else if (entry)
      state_q <= st_search;
    else
    begin
      case (state_q)
        st_search:
          if (sync_mode == mode_none)
          begin
            if (!cs_qual || carrier_q)
              state_q <= st_locked;
          end
          else if (rx_in.valid && sync_match && sync_allowed)
            state_q <= st_locked;
        st_locked: state_q <= st_locked;
        st_idle: state_q <= st_search;
        default: state_q <= st_idle;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Data path and outputs
  // ----------------------------------------------------------------
  always_ff @(posedge mclk)
  begin
    if (!rst_b)
    begin
      sync_found <= 1'b0;
      data_write <= 1'b0;
      data_byte <= 8'h00;
      data_q <= 8'h00;
      filter_enable <= 1'b0;
      general_pin <= 1'b0;
      tx_invert <= 1'b0;
      phase_shaping <= 3'h0;
      status_byte_q <= 8'h00;
    end
    else
    begin
      sync_found <= (state_q == st_locked);
      // bytes and filtering only after sync
      data_write <= byte_valid && (state_q == st_locked);
      filter_enable <= (state_q == st_locked);
      if (byte_valid && state_q == st_locked)
      begin
        data_byte <= byte_data;
        data_q <= byte_data;
      end
      // captured strength in first status byte
      if (payload_done && packet_control_one_q[append_bit])
        status_byte_q <= strength_q;
      case (output_select_code_q)
        sel_pq_reached: general_pin <= pq_reached;
        sel_carrier: general_pin <= carrier_q;
        default: general_pin <= 1'b0;
      endcase
      tx_invert <= msk_en;
      phase_shaping <= msk_en ? frequency_deviation_q[2:0] : 3'h0;
    end
  end

  // ----------------------------------------------------------------
  // Strength latch and carrier sense
  // ----------------------------------------------------------------
  // period 8 * 2^filter length samples
  assign upd_period = 11'(base_update_cycles) << filt_len;
  assign upd_tick = strength_valid && (upd_count_q >= upd_period - 11'h001);

  always_ff @(posedge mclk)
  begin
    if (!rst_b)
      upd_count_q <= 11'h000;
    else if (entry || upd_tick)
      upd_count_q <= 11'h000;
    else if (strength_valid)
      upd_count_q <= upd_count_q + 11'h001;
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_b)
      strength_q <= 8'h00;
    else if (rx_enable && upd_tick && (state_q != st_locked || sync_mode == mode_none))
      strength_q <= strength_sample;
  end

  always_ff @(posedge mclk)
  begin
    logic signed [8:0] thr;
    logic signed [8:0] cur;
    logic signed [8:0] diff;
    logic signed [8:0] step;
    thr = abs_base_hdb + mag_step_hdb * $signed({5'h00, target_magnitude})
      + 9'sd2 * $signed({{5{abs_offset[3]}}, abs_offset});
    cur = $signed({strength_sample[7], strength_sample});
    diff = cur - $signed({prev_strength_q[7], prev_strength_q});
    step = (rel_thr == 2'd1) ? 9'sd12 : (rel_thr == 2'd2) ? 9'sd20 : 9'sd28;
    if (!rst_b)
    begin
      carrier_q <= 1'b0;
      prev_strength_q <= 8'h00;
    end
    else if (!rx_enable)
      carrier_q <= 1'b0;
    else if (upd_tick)
    begin
      prev_strength_q <= strength_sample;
      if (rel_thr != 2'd0)
      begin
        if (diff >= step)
          carrier_q <= 1'b1;
        else if (diff <= -step)
          carrier_q <= 1'b0;
      end
      // offset shifts threshold in 1 dB steps
      else if (cur > thr)
        carrier_q <= 1'b1;
      else if (cur < thr - hyst_hdb)
        carrier_q <= 1'b0;
    end
  end

endmodule

// [shared/rxq_pkg.sv]
/*
  Constants, register map and receive types for the receive signal
  qualifier. Assumes a single 250 MHz clock and an APB master.
*/
// What this block does
// - mode field selects sync match criterion
// - upper modes also require carrier sense
// - no data or filtering before sync
// - quality counter plus one on toggle
// - quality counter minus eight on repeat
// - sync allowed only above 4x threshold
// - zero threshold disables quality gating
// - quality reached to status and pin 1000
// - strength tracks until sync, then frozen, except in mode none where it keeps tracking
// - strength is two's complement half-dB byte
// - strength update rate follows filter length
// - captured strength goes in first status byte
// - absolute threshold sense with hysteresis
// - relative step sense between samples
// - carrier sense to status and pin 1110
// - offset shifts absolute threshold from minus 8 to plus 7
// - minimum shift keying bits inverted
// - deviation mantissa sets phase shaping
// - defaults offset 0, target magnitude 11
// - 32-bit modes repeat sync word twice
package rxq_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] modem_config_two_off = 8'h00;
  localparam logic [7:0] packet_control_one_off = 8'h04;
  localparam logic [7:0] gain_control_one_off = 8'h08;
  localparam logic [7:0] gain_control_two_off = 8'h0C;
  localparam logic [7:0] sync_word_off = 8'h10;
  localparam logic [7:0] frequency_deviation_reg_off = 8'h14;
  localparam logic [7:0] pin_output_config_off = 8'h18;
  localparam logic [7:0] signal_strength_off = 8'h1C;
  localparam logic [7:0] packet_status_reg_off = 8'h20;
  localparam logic [7:0] status_byte_off = 8'h24;
  localparam logic [7:0] radio_data_register_off = 8'h28;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int sync_mode_lsb = 0;
  localparam int cs_qual_bit = 2;
  localparam int manchester_bit = 3;
  localparam int msk_bit = 4;
  localparam int pqt_lsb = 5;
  localparam int append_bit = 2;
  localparam int rel_thr_lsb = 4;
  localparam int filt_len_lsb = 6;
  localparam logic [7:0] modem_config_two_rst = 8'h03;
  localparam logic [7:0] packet_control_one_rst = 8'h04;
  localparam logic [7:0] gain_control_one_rst = 8'h00;
  localparam logic [7:0] gain_control_two_rst = 8'h03;
  localparam logic [15:0] sync_word_rst = 16'hD391;
  localparam logic [7:0] frequency_deviation_rst = 8'h47;
  localparam logic [3:0] pin_output_rst = 4'h0;
  localparam logic [3:0] sel_pq_reached = 4'h8;
  localparam logic [3:0] sel_carrier = 4'hE;
  localparam logic [3:0] target_magnitude_rst = 4'hB;

  // Absolute threshold base in half-dB (arbitrary neutral level)
  localparam logic signed [8:0] abs_base_hdb = -9'sd180;
  localparam logic signed [8:0] mag_step_hdb = 9'sd6;
  localparam logic signed [8:0] hyst_hdb = 9'sd4;
  localparam logic [7:0] pq_repeat_step = 8'h08;
  localparam logic [7:0] pq_max = 8'hFF;
  localparam int base_update_cycles = 8;

  typedef enum logic [2:0]
  {
    mode_none = 3'b000,
    mode_15of16 = 3'b001,
    mode_16of16 = 3'b010,
    mode_30of32 = 3'b011
  } sync_mode_t;

  typedef enum logic [1:0]
  {
    st_idle = 2'b00,
    st_search = 2'b01,
    st_locked = 2'b10
  } rx_state_t;

  typedef struct packed
  {
    logic valid;
    logic bit_val;
  } rx_bit_t;

endpackage

// [tb/demod_model.sv]
/* Front end model: demodulator bits, strength samples, bytes.
   Assumes one calling process and filter length 0. */
`timescale 1ns/10ps
module demod_model
  import rxq_pkg::*;
(
  // Clock
  input wire logic mclk,
  // Toward the qualifier
  output rx_bit_t rx_in,
  output logic strength_valid,
  output logic [7:0] strength_sample,
  output logic byte_valid,
  output logic [7:0] byte_data,
  output logic payload_done
);
  initial
  begin
    rx_in = '0;
    strength_valid = 1'b0;
    strength_sample = 8'h00;
    byte_valid = 1'b0;
    byte_data = 8'h00;
    payload_done = 1'b0;
  end
  // Idle lines show the inverse so stale values never pass
  task automatic send_bits(input logic [31:0] w, input int n);
    for (int i = n - 1; i >= 0; i--)
    begin
      @(posedge mclk);
      rx_in <= '{valid: 1'b1, bit_val: w[i]};
      @(posedge mclk);
      rx_in <= '{valid: 1'b0, bit_val: !w[i]};
    end
  endtask
  // Eight pulses cover one full update period
  task automatic strength(input logic [7:0] v);
    for (int i = 0; i < 8; i++)
    begin
      @(posedge mclk);
      strength_valid <= 1'b1;
      strength_sample <= v;
      @(posedge mclk);
      strength_valid <= 1'b0;
      strength_sample <= ~v;
    end
  endtask
  task automatic put_byte(input logic [7:0] b);
    @(posedge mclk);
    byte_valid <= 1'b1;
    byte_data <= b;
    @(posedge mclk);
    byte_valid <= 1'b0;
    byte_data <= ~b;
  endtask
  task automatic end_payload();
    @(posedge mclk);
    payload_done <= 1'b1;
    @(posedge mclk);
    payload_done <= 1'b0;
  endtask
endmodule

// [tb/rxq_chk_sva.sv]
/* Port checker for the receive qualifier.
   Bound to the top module; one clock domain. */
`timescale 1ns/10ps
module rxq_chk
  import rxq_pkg::*;
(
  // Clock and bus
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Receive side
  input wire logic rx_enable,
  input wire logic byte_valid,
  input wire logic [7:0] byte_data,
  input wire logic sync_found,
  input wire logic data_write,
  input wire logic [7:0] data_byte,
  input wire logic tx_invert,
  input wire logic [2:0] phase_shaping
);
  logic wr_cfg;
  logic wr_dev;
  logic msk_w;
  logic [2:0] dev_w;
  assign wr_cfg = psel && penable && pwrite && paddr == modem_config_two_off;
  assign wr_dev = psel && penable && pwrite && paddr == frequency_deviation_reg_off;
  assign msk_w = pwdata[msk_bit];
  assign dev_w = pwdata[2:0];
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_b);
  // ---------
  // Properties
  // ---------
  property p_ready;
    psel && !penable |=> pready ##1 !pready;
  endproperty
  a_ready: assert property (p_ready) else $error("pready not one cycle");
  property p_unmapped;
    psel && !penable && !pwrite && paddr > radio_data_register_off |=> pslverr;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read accepted");
  property p_mapped;
    psel && !penable && paddr[1:0] == 2'h0 && paddr <= radio_data_register_off |=> !pslverr;
  endproperty
  a_mapped: assert property (p_mapped) else $error("mapped access refused");
  property p_err_data;
    pslverr |-> pready && prdata == 32'h0;
  endproperty
  a_err_data: assert property (p_err_data) else $error("error without zero data");
  property p_no_early;
    !sync_found [*2] |-> !data_write;
  endproperty
  a_no_early: assert property (p_no_early) else $error("data before sync");
  property p_byte;
    data_write |-> $past(byte_valid) && data_byte == $past(byte_data);
  endproperty
  a_byte: assert property (p_byte) else $error("data byte mismatch");
  property p_invert;
    wr_cfg |=> ##1 tx_invert == $past(msk_w, 2);
  endproperty
  a_invert: assert property (p_invert) else $error("invert not from config");
  property p_shaping;
    wr_dev |=> ##1 phase_shaping == (tx_invert ? $past(dev_w, 2) : 3'h0);
  endproperty
  a_shaping: assert property (p_shaping) else $error("shaping not from field");
  property p_idle;
    !rx_enable [*3] |-> !sync_found;
  endproperty
  a_idle: assert property (p_idle) else $error("lock held outside receive");
  c_data: cover property (data_write);
  c_err: cover property (pslverr);
  c_msk_sync: cover property ($rose(sync_found) && tx_invert);
endmodule

bind rx_sync_word_qualifier rxq_chk chk_u (.mclk(mclk), .rst_b(rst_b), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .rx_enable(rx_enable), .byte_valid(byte_valid), .byte_data(byte_data), .sync_found(sync_found),
  .data_write(data_write), .data_byte(data_byte), .tx_invert(tx_invert), .phase_shaping(phase_shaping));

// [tb/test_rx_sync_word_qualifier.sv]
/* Self-checking bench for the receive qualifier.
   Assumes the bound checker and the front end model. */
`timescale 1ns/10ps
module test_rx_sync_word_qualifier;
  import rxq_pkg::*;
  logic mclk;
  logic rst_b;
  logic psel;
  logic penable;
  logic pwrite;
  logic [7:0] paddr;
  logic [31:0] pwdata;
  logic rx_enable;
  logic filter_enable;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic err_seen;
  rx_bit_t rx_in;
  logic strength_valid;
  logic [7:0] strength_sample;
  logic byte_valid;
  logic [7:0] byte_data;
  logic payload_done;
  logic sync_found;
  logic data_write;
  logic [7:0] data_byte;
  logic general_pin;
  logic tx_invert;
  logic [2:0] phase_shaping;
  int num_errors = 0;
  int n_tests = 0;
  int cyc = 0;
  int n_dw = 0;
  logic [31:0] r;
  initial
  begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  rx_sync_word_qualifier dut_u (.mclk(mclk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .rx_enable(rx_enable),
    .rx_in(rx_in), .strength_valid(strength_valid), .strength_sample(strength_sample), .byte_valid(byte_valid),
    .byte_data(byte_data), .payload_done(payload_done), .sync_found(sync_found), .data_write(data_write),
    .data_byte(data_byte), .filter_enable(filter_enable), .general_pin(general_pin), .tx_invert(tx_invert),
    .phase_shaping(phase_shaping));
  demod_model dm_u (.mclk(mclk), .rx_in(rx_in), .strength_valid(strength_valid),
    .strength_sample(strength_sample), .byte_valid(byte_valid), .byte_data(byte_data),
    .payload_done(payload_done));
  // Hang guard well above the whole run
  always @(posedge mclk)
  begin
    cyc++;
    if (data_write === 1'b1)
      n_dw++;
    if (cyc > 20000)
    begin
      num_errors++;
      finish_test();
    end
  end
  task automatic finish_test();
    $display("errors %0d checks %0d", num_errors, n_tests);
    if (num_errors == 0 && n_tests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e)
    begin
      num_errors++;
      $display("CHECK FAILED %s exp %h got %h", what, e, g);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do
      @(posedge mclk);
    while (pready !== 1'b1);
    r = prdata;
    err_seen = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rchk(input string what, input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(what, e, r);
  endtask
  task automatic enter_rx();
    @(posedge mclk);
    rx_enable <= 1'b0;
    repeat (3) @(posedge mclk);
    rx_enable <= 1'b1;
  endtask
  task automatic wait_sync(input logic e);
    for (int i = 0; i < 20 && sync_found !== 1'b1; i++)
      @(posedge mclk);
    chk("sync_found", {31'h0, e}, {31'h0, sync_found});
  endtask
  // ---------
  // Scenarios
  // ---------
  task automatic scen_reset_values();
    rchk("modem cfg", modem_config_two_off, 32'h03);
    rchk("pkt ctrl", packet_control_one_off, 32'h04);
    rchk("offset", gain_control_one_off, 32'h00);
    rchk("target", gain_control_two_off, 32'h0B);
    rchk("sync word", sync_word_off, 32'hD391);
    rchk("deviation", frequency_deviation_reg_off, 32'h47);
    rchk("unmapped", 8'h40, 32'h0);
    chk("unmapped err", 32'h1, {31'h0, err_seen});
  endtask
  task automatic scen_modes();
    logic [2:0] md[5] = '{3'h1, 3'h2, 3'h2, 3'h3, 3'h0};
    logic [31:0] wd[5] = '{32'hD390, 32'hD390, 32'hD391, 32'hD391D391, 32'h0};
    int nb[5] = '{16, 16, 16, 32, 0};
    logic ex[5] = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b1};
    for (int i = 0; i < 5; i++)
    begin
      apb(1'b1, modem_config_two_off, {29'h0, md[i]});
      enter_rx();
      dm_u.send_bits(wd[i], nb[i]);
      wait_sync(ex[i]);
    end
  endtask
  task automatic scen_strength();
    apb(1'b1, modem_config_two_off, 32'h02);
    enter_rx();
    dm_u.strength(8'hF0);
    rchk("strength", signal_strength_off, 32'hF0);
    dm_u.put_byte(8'h5A);
    repeat (2) @(posedge mclk);
    chk("early writes", 32'h0, n_dw);
    chk("filter off", 32'h0, {31'h0, filter_enable});
    dm_u.send_bits(32'hD391, 16);
    wait_sync(1'b1);
    chk("filter on", 32'h1, {31'h0, filter_enable});
    dm_u.put_byte(8'hA5);
    rchk("data", radio_data_register_off, 32'hA5);
    chk("writes", 32'h1, n_dw);
    dm_u.strength(8'h20);
    rchk("frozen", signal_strength_off, 32'hF0);
    dm_u.end_payload();
    rchk("status byte", status_byte_off, 32'hF0);
    enter_rx();
    dm_u.strength(8'h20);
    rchk("released", signal_strength_off, 32'h20);
  endtask
  task automatic scen_quality();
    apb(1'b1, pin_output_config_off, 32'h8);
    apb(1'b1, modem_config_two_off, 32'h22);
    enter_rx();
    dm_u.send_bits(32'hAA, 8);
    rchk("pq reached", packet_status_reg_off, 32'h41);
    chk("pq pin", 32'h1, {31'h0, general_pin});
    dm_u.send_bits(32'h0, 2);
    rchk("pq dropped", packet_status_reg_off, 32'h01);
    dm_u.send_bits(32'hD391, 16);
    wait_sync(1'b0);
  endtask
  task automatic scen_carrier();
    apb(1'b1, pin_output_config_off, 32'hE);
    apb(1'b1, modem_config_two_off, 32'h06);
    enter_rx();
    dm_u.strength(8'h80);
    dm_u.send_bits(32'hD391, 16);
    wait_sync(1'b0);
    dm_u.strength(8'hC0);
    apb(1'b0, packet_status_reg_off, 32'h0);
    chk("carrier on", 32'h1, {31'h0, r[7]});
    chk("cs pin", 32'h1, {31'h0, general_pin});
    dm_u.send_bits(32'hD391, 16);
    wait_sync(1'b1);
    dm_u.strength(8'h80);
    apb(1'b0, packet_status_reg_off, 32'h0);
    chk("carrier off", 32'h0, {31'h0, r[7]});
    chk("cs pin off", 32'h0, {31'h0, general_pin});
    // Offset -7 dB lowers threshold to -128 half-dB
    apb(1'b1, gain_control_one_off, 32'h09);
    dm_u.strength(8'h8C);
    apb(1'b0, packet_status_reg_off, 32'h0);
    chk("offset carrier", 32'h1, {31'h0, r[7]});
    // Offset +7 dB keeps absolute sense off, step 6 dB
    apb(1'b1, gain_control_one_off, 32'h17);
    dm_u.strength(8'h80);
    dm_u.strength(8'h90);
    apb(1'b0, packet_status_reg_off, 32'h0);
    chk("step rise", 32'h1, {31'h0, r[7]});
    dm_u.strength(8'h80);
    apb(1'b0, packet_status_reg_off, 32'h0);
    chk("step fall", 32'h0, {31'h0, r[7]});
  endtask
  task automatic scen_msk();
    apb(1'b1, frequency_deviation_reg_off, 32'h45);
    // Manchester stays clear with shift keying
    apb(1'b1, modem_config_two_off, 32'h12);
    // Outputs follow the register one cycle later
    repeat (2) @(posedge mclk);
    chk("invert", 32'h1, {31'h0, tx_invert});
    chk("shaping", 32'h5, {29'h0, phase_shaping});
    enter_rx();
    dm_u.send_bits(32'hD391, 16);
    wait_sync(1'b0);
    dm_u.send_bits(32'h2C6E, 16);
    wait_sync(1'b1);
  endtask
  initial
  begin
    rst_b <= 1'b0;
    psel <= 1'b0;
    penable <= 1'b0;
    pwrite <= 1'b0;
    paddr <= 8'h00;
    pwdata <= 32'h0;
    rx_enable <= 1'b0;
    repeat (6) @(posedge mclk);
    rst_b <= 1'b1;
    scen_reset_values();
    scen_modes();
    scen_strength();
    scen_quality();
    scen_carrier();
    scen_msk();
    finish_test();
  end
endmodule
